// File: lin_sbc_host_model.sv
// Purpose: Serial port master standing in for the microcontroller
// Assumes: Inputs of the device are sampled on rising mclk_i
// Notes: Drives only on falling mclk_i; clock idles low outside frames
module lin_sbc_host_model (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic frame_o,
  output logic scl_o,
  output logic sda_o,
  output logic sda_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: no frame, transmit line driven recessive high
  initial begin
    frame_o = 1'b0;
    scl_o = 1'b0;
    sda_o = 1'b1;
    sda_oe_n_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // Launch on rise, device samples on fall; 3 high, 2 low for margin
  task automatic bit_cycle(input logic drive, input logic b, output logic s);
    scl_o = 1'b1;
    sda_oe_n_o = !drive;
    sda_o = b;
    tick(3);
    s = sda_i;
    scl_o = 1'b0;
    tick(2);
  endtask

  // Bytes go most significant bit first
  task automatic put_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(1'b1, b[i], s);
  endtask

  // Line released while the device answers
  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_cycle(1'b0, 1'b1, b[i]);
  endtask

  // Command: direction, length code, 5-bit start address
  task automatic open_frame(input logic rd, input logic [1:0] len,
                            input logic [4:0] addr);
    frame_o = 1'b1;
    tick(2);
    put_byte({rd, len, addr});
  endtask

  task automatic close_frame();
    tick(1);
    frame_o = 1'b0;
    sda_o = 1'b1;
    sda_oe_n_o = 1'b0;
    tick(3);
  endtask

  // Plain transmit level between frames
  task automatic tx_level(input logic v);
    sda_o = v;
    sda_oe_n_o = 1'b0;
  endtask
endmodule

// File: lin_sbc_pkg.sv
// Purpose: Shared constants for the LIN companion register bank
// Assumes: 250 MHz system clock, 8-bit registers, 5-bit addresses
// Notes: Offsets, reset values, masks and timing counts live here
package lin_sbc_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  // Register offsets
  localparam logic [4:0] OFF_DEV_CFG = 5'h03;
  localparam logic [4:0] OFF_DEV_CTRL = 5'h04;
  localparam logic [4:0] OFF_TMP_SHDN = 5'h05;
  localparam logic [4:0] OFF_WDG_TRIG = 5'h06;
  localparam logic [4:0] OFF_LSD_DATA = 5'h07;
  localparam logic [4:0] OFF_DIAG_LO = 5'h08;
  localparam logic [4:0] OFF_DIAG_MID = 5'h09;
  // Reset values
  localparam logic [7:0] RST_DEV_CFG = 8'h0F;
  localparam logic [7:0] RST_DEV_CTRL = 8'h01;
  localparam logic [7:0] RST_TMP_SHDN = 8'h00;
  localparam logic [7:0] RST_LSD_DATA = 8'h00;
  localparam logic [7:0] RST_DIAG_LO = 8'h03;
  localparam logic [7:0] RST_DIAG_MID = 8'h00;
  // Implemented bits; everything else reads zero
  localparam logic [7:0] MASK_DEV_CFG = 8'h0F;
  localparam logic [7:0] MASK_DEV_CTRL = 8'h01;
  localparam logic [7:0] MASK_TMP_SHDN = 8'h01;
  localparam logic [7:0] MASK_LSD_DATA = 8'hFF;
  localparam logic [7:0] MASK_DIAG_LO = 8'hDF;
  localparam logic [7:0] MASK_DIAG_MID = 8'h03;
  // Field positions
  localparam int unsigned BIT_LIN_EN = 3;
  localparam int unsigned BIT_TSD = 0;
  localparam int unsigned BIT_TRIG = 0;
  localparam int unsigned DG_SUPPLY_UV = 0;
  localparam int unsigned DG_REG_UV = 1;
  localparam int unsigned DG_HOT_RESET = 2;
  localparam int unsigned DG_HOT_WARN = 3;
  localparam int unsigned DG_SUPPLY_OV = 4;
  localparam int unsigned DG_WAKE = 6;
  localparam int unsigned DG_WDG_TMO = 7;
  localparam int unsigned DG_TX_STUCK = 0;
  localparam int unsigned DG_TSD = 1;
  // Command byte layout
  localparam int unsigned CMD_RD_BIT = 7;
  localparam int unsigned CMD_LEN_HI = 6;
  localparam int unsigned CMD_LEN_LO = 5;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SLOW_CLK_HZ = 128000;
  localparam int unsigned TRIG_CLR_SLOW_CYC = 2;
  localparam int unsigned TRIG_CLR_CYC =
    (TRIG_CLR_SLOW_CYC * 1000000000 / SLOW_CLK_HZ) / CLK_PERIOD_NS;
  localparam int unsigned TX_TIMEOUT_MS = 1000;
  localparam int unsigned TX_TIMEOUT_CYC =
    TX_TIMEOUT_MS * (1000000 / CLK_PERIOD_NS);
  typedef enum logic [1:0] {SP_CMD, SP_WRITE, SP_READ, SP_DONE} sp_state_t;
endpackage

// File: lin_sbc_regs.sv
// Purpose: Control and diagnosis register bank behind the serial port
// Assumes: Serial port mode entry is decoded outside (sp_frame_i)
// Notes: vcc_rstn_i resets regulator-domain registers, rstn_i the rest
// Notes on behaviour
// - Seven byte registers at offsets 03 to 09, reached serially
// - Offset 03 bit 3 enables transceiver
// - Offset 04 resets to 01 on supply
// - Offset 05 bit 0 requests temporary shutdown
// - Trigger outside open window raises reset
// - Trigger restarts counter, bit self-clears quickly
// - Offset 07 byte is read-write, resets zero
// - Offset 08 holds low diag byte, 03
// - Offset 09 holds mid diag byte, zero
// - Supply undervoltage flag sticky until read
// - Regulator undervoltage flag sticky until read
// - Overheat reset flag cleared by read
// - Overheat warning flag cleared by read
// - Supply overvoltage flag cleared by read
// - Remote wakeup flag; bit 5 reserved
// - Watchdog timeout flag cleared by read
// - Transmit low over one second flagged
// - Entering temporary shutdown flagged, read-cleared
// - Command byte: direction, length, address, increment
module lin_sbc_regs #(
  parameter int unsigned TX_TIMEOUT_CYC = lin_sbc_pkg::TX_TIMEOUT_CYC
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic vcc_rstn_i,
  input wire logic sp_frame_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic wdg_window_open_i,
  input wire logic supply_uv_i,
  input wire logic regulator_uv_i,
  input wire logic overheat_i,
  input wire logic overheat_warn_i,
  input wire logic supply_ov_i,
  input wire logic remote_wake_i,
  input wire logic wdg_timeout_i,
  output logic lin_tx_enable_o,
  output logic device_control_o,
  output logic temp_shutdown_o,
  output logic [7:0] low_side_data_o,
  output logic wdg_restart_o,
  output logic reset_req_o,
  output logic [7:0] diag_low_o,
  output logic [7:0] diag_mid_o
);
  localparam int unsigned TXC_W = $clog2(TX_TIMEOUT_CYC + 1);
  localparam int unsigned TRC_W = $clog2(lin_sbc_pkg::TRIG_CLR_CYC + 1);
  localparam logic [TXC_W-1:0] TX_LIMIT = TXC_W'(TX_TIMEOUT_CYC);
  localparam logic [TRC_W-1:0] TRIG_LIMIT =
    TRC_W'(lin_sbc_pkg::TRIG_CLR_CYC);

  lin_sbc_pkg::sp_state_t state_q;
  lin_sbc_pkg::sp_state_t state_d;
  logic [4:0] addr_q;
  logic [3:0] left_q;
  logic [7:0] cfg_q;
  logic [7:0] ctrl_q;
  logic [7:0] tsd_q;
  logic [7:0] lsd_q;
  logic trig_q;
  logic [TRC_W-1:0] trig_cnt_q;
  logic tsd_prev_q;
  logic [TXC_W-1:0] tx_low_cnt_q;
  logic restart_q;
  logic reset_req_q;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic tx_take;
  logic [7:0] rd_data;
  logic wr_stb;
  logic [7:0] diag_lo;
  logic [7:0] diag_mid;
  logic [7:0] lo_set;
  logic [1:0] mid_set;
  logic [7:0] lo_clr;
  logic [1:0] mid_clr;
  logic trig_wr;
  logic tx_stuck;
  logic byte_done;

  // Register read view; reserved bits and unmapped offsets read zero
  function automatic logic [7:0] rd_value(input logic [4:0] a,
    input logic [7:0] cfg, input logic [7:0] ctl, input logic [7:0] tsd,
    input logic [7:0] lsd, input logic [7:0] dlo, input logic [7:0] dmi);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      lin_sbc_pkg::OFF_DEV_CFG: v = cfg & lin_sbc_pkg::MASK_DEV_CFG;
      lin_sbc_pkg::OFF_DEV_CTRL: v = ctl & lin_sbc_pkg::MASK_DEV_CTRL;
      lin_sbc_pkg::OFF_TMP_SHDN: v = tsd & lin_sbc_pkg::MASK_TMP_SHDN;
      lin_sbc_pkg::OFF_LSD_DATA: v = lsd;
      lin_sbc_pkg::OFF_DIAG_LO: v = dlo & lin_sbc_pkg::MASK_DIAG_LO;
      lin_sbc_pkg::OFF_DIAG_MID: v = dmi & lin_sbc_pkg::MASK_DIAG_MID;
      default: v = 8'h00; // Trigger is write-only
    endcase
    return v;
  endfunction

  lin_sbc_sp_shift u_shift (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .frame_i(sp_frame_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .tx_en_i(state_q == lin_sbc_pkg::SP_READ),
    .tx_byte_i(rd_data),
    .sda_o(sda_o),
    .tx_take_o(tx_take),
    .rx_byte_o(rx_byte),
    .rx_valid_o(rx_valid)
  );

  // Decode of the serial access
  assign rd_data = rd_value(addr_q, cfg_q, ctrl_q, tsd_q, lsd_q,
    diag_lo, diag_mid);
  assign wr_stb = rx_valid & (state_q == lin_sbc_pkg::SP_WRITE);
  assign byte_done = rx_valid & (state_q != lin_sbc_pkg::SP_CMD);
  assign trig_wr = wr_stb & (addr_q == lin_sbc_pkg::OFF_WDG_TRIG) &
    rx_byte[lin_sbc_pkg::BIT_TRIG];
  assign sda_oe_n_o = ~(sp_frame_i & (state_q == lin_sbc_pkg::SP_READ));

  // Frame sequencer: command, then 1/2/4/8 data bytes
  always_comb begin
    state_d = state_q;
    case (state_q)
      lin_sbc_pkg::SP_CMD: begin
        if (rx_valid) begin
          state_d = rx_byte[lin_sbc_pkg::CMD_RD_BIT] ?
            lin_sbc_pkg::SP_READ : lin_sbc_pkg::SP_WRITE;
        end
      end
      lin_sbc_pkg::SP_WRITE, lin_sbc_pkg::SP_READ: begin
        if (byte_done && left_q == 4'h1) begin
          state_d = lin_sbc_pkg::SP_DONE;
        end
      end
      lin_sbc_pkg::SP_DONE: state_d = lin_sbc_pkg::SP_DONE;
      default: state_d = lin_sbc_pkg::SP_CMD;
    endcase
  end

  // Address and byte count; further bytes use the next address
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !sp_frame_i) begin
      state_q <= lin_sbc_pkg::SP_CMD;
      addr_q <= 5'h00;
      left_q <= 4'h0;
    end else begin
      state_q <= state_d;
      if (rx_valid && state_q == lin_sbc_pkg::SP_CMD) begin
        addr_q <= rx_byte[4:0];
        left_q <= 4'h1 << {rx_byte[lin_sbc_pkg::CMD_LEN_HI],
          rx_byte[lin_sbc_pkg::CMD_LEN_LO]};
      end else if (byte_done) begin
        addr_q <= addr_q + 5'h01;
        left_q <= left_q - 4'h1;
      end
    end
  end

  // Regulator-domain registers, loaded on the VCC reset
  always_ff @(posedge mclk_i) begin
    if (!vcc_rstn_i) begin
      cfg_q <= lin_sbc_pkg::RST_DEV_CFG;
      tsd_q <= lin_sbc_pkg::RST_TMP_SHDN;
      lsd_q <= lin_sbc_pkg::RST_LSD_DATA;
    end else if (wr_stb) begin
      if (addr_q == lin_sbc_pkg::OFF_DEV_CFG) begin
        cfg_q <= rx_byte & lin_sbc_pkg::MASK_DEV_CFG;
      end
      if (addr_q == lin_sbc_pkg::OFF_TMP_SHDN) begin
        tsd_q <= rx_byte & lin_sbc_pkg::MASK_TMP_SHDN;
      end
      if (addr_q == lin_sbc_pkg::OFF_LSD_DATA) begin
        lsd_q <= rx_byte & lin_sbc_pkg::MASK_LSD_DATA;
      end
    end
  end

  // Supply-domain control register
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ctrl_q <= lin_sbc_pkg::RST_DEV_CTRL;
    end else if (wr_stb && addr_q == lin_sbc_pkg::OFF_DEV_CTRL) begin
      ctrl_q <= rx_byte & lin_sbc_pkg::MASK_DEV_CTRL;
    end
  end

  // Trigger bit self-clears after TRIG_LIMIT cycles, just inside two slow-clock periods
  always_ff @(posedge mclk_i) begin
    if (!vcc_rstn_i) begin
      trig_q <= 1'b0;
      trig_cnt_q <= '0;
      restart_q <= 1'b0;
      reset_req_q <= 1'b0;
    end else begin
      restart_q <= trig_wr;
      reset_req_q <= trig_wr & ~wdg_window_open_i;
      if (trig_wr) begin
        trig_q <= 1'b1;
        trig_cnt_q <= '0;
      end else if (trig_q) begin
        trig_cnt_q <= trig_cnt_q + 1'b1;
        if (trig_cnt_q == TRIG_LIMIT - 1'b1) begin
          trig_q <= 1'b0;
        end
      end
    end
  end

  // Transmit-low timer; the shared pin only counts outside a frame
  assign tx_stuck = (tx_low_cnt_q == TX_LIMIT);
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || sp_frame_i || sda_i) begin
      tx_low_cnt_q <= '0;
    end else if (!tx_stuck) begin
      tx_low_cnt_q <= tx_low_cnt_q + 1'b1;
    end
  end

  // Edge detect for shutdown entry
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tsd_prev_q <= 1'b0;
    end else begin
      tsd_prev_q <= tsd_q[lin_sbc_pkg::BIT_TSD];
    end
  end

  // Flag events; a read clears only the bits it returned
  always_comb begin
    lo_set = 8'h00;
    lo_set[lin_sbc_pkg::DG_SUPPLY_UV] = supply_uv_i;
    lo_set[lin_sbc_pkg::DG_REG_UV] = regulator_uv_i;
    lo_set[lin_sbc_pkg::DG_HOT_RESET] = overheat_i;
    lo_set[lin_sbc_pkg::DG_HOT_WARN] = overheat_warn_i;
    lo_set[lin_sbc_pkg::DG_SUPPLY_OV] = supply_ov_i;
    lo_set[lin_sbc_pkg::DG_WAKE] = remote_wake_i;
    lo_set[lin_sbc_pkg::DG_WDG_TMO] = wdg_timeout_i;
    mid_set = 2'h0;
    mid_set[lin_sbc_pkg::DG_TX_STUCK] = tx_stuck;
    mid_set[lin_sbc_pkg::DG_TSD] = tsd_q[lin_sbc_pkg::BIT_TSD] &
      ~tsd_prev_q;
  end
  assign lo_clr = (tx_take && addr_q == lin_sbc_pkg::OFF_DIAG_LO) ?
    rd_data : 8'h00;
  assign mid_clr = (tx_take && addr_q == lin_sbc_pkg::OFF_DIAG_MID) ?
    rd_data[1:0] : 2'h0;

  lin_sbc_sticky #(
    .W(8),
    .RST(lin_sbc_pkg::RST_DIAG_LO),
    .MASK(lin_sbc_pkg::MASK_DIAG_LO)
  ) u_diag_lo (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .set_i(lo_set),
    .clr_i(lo_clr),
    .q_o(diag_lo)
  );

  lin_sbc_sticky #(
    .W(8),
    .RST(lin_sbc_pkg::RST_DIAG_MID),
    .MASK(lin_sbc_pkg::MASK_DIAG_MID)
  ) u_diag_mid (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .set_i({6'h00, mid_set}),
    .clr_i({6'h00, mid_clr}),
    .q_o(diag_mid)
  );

  // Block outputs straight from registers
  assign lin_tx_enable_o = cfg_q[lin_sbc_pkg::BIT_LIN_EN];
  assign device_control_o = ctrl_q[0];
  assign temp_shutdown_o = tsd_q[lin_sbc_pkg::BIT_TSD];
  assign low_side_data_o = lsd_q;
  assign wdg_restart_o = restart_q;
  assign reset_req_o = reset_req_q;
  assign diag_low_o = diag_lo;
  assign diag_mid_o = diag_mid;

  // Checks on the register bank
  AST_WDG_RESET: assert property (@(posedge mclk_i) disable iff (!vcc_rstn_i)
    trig_wr && !wdg_window_open_i |=> reset_req_o)
    else $error("early or late trigger did not raise reset");
  AST_WDG_NO_RESET: assert property (@(posedge mclk_i)
    disable iff (!vcc_rstn_i)
    trig_wr && wdg_window_open_i |=> !reset_req_o && wdg_restart_o)
    else $error("in-window trigger mishandled");
  AST_TRIG_CLEAR: assert property (@(posedge mclk_i) disable iff (!vcc_rstn_i)
    trig_q |-> trig_cnt_q < TRIG_LIMIT)
    else $error("trigger bit held too long");
  AST_LIN_EN: assert property (@(posedge mclk_i) disable iff (!vcc_rstn_i)
    wr_stb && addr_q == lin_sbc_pkg::OFF_DEV_CFG
    |=> lin_tx_enable_o == $past(rx_byte[lin_sbc_pkg::BIT_LIN_EN]))
    else $error("transceiver enable not written");
  AST_STICKY: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    diag_lo[lin_sbc_pkg::DG_SUPPLY_UV] && !lo_clr[0]
    |=> diag_lo[lin_sbc_pkg::DG_SUPPLY_UV])
    else $error("undervoltage flag lost without a read");
  AST_SET_WINS: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    regulator_uv_i |=> diag_lo[lin_sbc_pkg::DG_REG_UV])
    else $error("regulator flag not set");
  AST_READ_CLEAR: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    lo_clr[lin_sbc_pkg::DG_HOT_RESET] && !overheat_i
    |=> !diag_lo[lin_sbc_pkg::DG_HOT_RESET])
    else $error("read did not clear overheat flag");
  AST_RESERVED: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !diag_lo[5] && diag_mid[7:2] == 6'h00 && cfg_q[7:4] == 4'h0)
    else $error("reserved bit set");
  AST_TSD_FLAG: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(temp_shutdown_o) |=> diag_mid[lin_sbc_pkg::DG_TSD])
    else $error("shutdown entry not flagged");
  AST_TX_STUCK: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    tx_stuck |=> diag_mid[lin_sbc_pkg::DG_TX_STUCK])
    else $error("stuck transmit not flagged");
  AST_ADDR_INC: assert property (@(posedge mclk_i)
    disable iff (!rstn_i || !sp_frame_i)
    byte_done |=> addr_q == $past(addr_q) + 5'h01)
    else $error("address did not advance");
endmodule

// File: lin_sbc_sp_shift.sv
// Purpose: Bit engine of the two-wire serial port
// Assumes: Serial clock and data already synchronous to mclk_i
// Notes: Samples on falling serial clock, drives on rising edge
module lin_sbc_sp_shift (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic frame_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic tx_en_i,
  input wire logic [7:0] tx_byte_i,
  output logic sda_o,
  output logic tx_take_o,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o
);
  logic scl_q;
  logic [2:0] cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic fall;
  logic rise;

  assign fall = scl_q & ~scl_i;
  assign rise = ~scl_q & scl_i;
  assign tx_take_o = frame_i & rise & tx_en_i & (cnt_q == 3'h0);
  assign rx_byte_o = {rx_q[6:0], sda_i};
  assign rx_valid_o = frame_i & fall & (cnt_q == 3'h7);
  assign sda_o = tx_q[7];

  // Edge history and bit counter; idle frame restarts the byte
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !frame_i) begin
      scl_q <= 1'b0;
      cnt_q <= 3'h0;
      rx_q <= 8'h00;
    end else begin
      scl_q <= scl_i;
      if (fall) begin
        cnt_q <= cnt_q + 3'h1;
        rx_q <= rx_byte_o;
      end
    end
  end

  // Transmit shifter, MSB first, moved on rising serial clock
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !frame_i) begin
      tx_q <= 8'hFF;
    end else if (tx_take_o) begin
      tx_q <= tx_byte_i;
    end else if (rise && tx_en_i) begin
      tx_q <= {tx_q[6:0], 1'b1};
    end
  end
endmodule

// File: lin_sbc_sticky.sv
// Purpose: Bank of sticky event flags, cleared by a read
// Assumes: Synchronous active-low reset
// Notes: A set in the clearing cycle wins, so no event is lost
module lin_sbc_sticky #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] RST = '0,
  parameter logic [W-1:0] MASK = '1
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] flag_q;
  logic [W-1:0] flag_d;

  // Set dominates clear; unmasked bits stay zero
  assign flag_d = ((flag_q & ~clr_i) | set_i) & MASK;
  assign q_o = flag_q;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      flag_q <= RST;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench for the LIN companion register bank
// Assumes: Host model owns the serial pins; 250 MHz clock
// Notes: Short transmit timeout parameter keeps the run brief
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TXTO = 50;
  logic mclk_i, rstn_i, vcc_rstn_i, win_open;
  logic [6:0] ev;
  logic frame, scl, host_sda, host_oe_n, dut_sda, dut_oe_n, sda_w;
  logic lin_en, dev_ctl, tsd, restart, rst_req;
  logic [7:0] lsd, dlo, dmi, got;
  logic [7:0] wdat [8];
  logic [7:0] expd [8];
  int miscompares = 0;
  int comparisons = 0;
  int n_restart = 0;
  int n_rstreq = 0;
  int unsigned pos [7] = '{lin_sbc_pkg::DG_SUPPLY_UV, lin_sbc_pkg::DG_REG_UV,
    lin_sbc_pkg::DG_HOT_RESET, lin_sbc_pkg::DG_HOT_WARN,
    lin_sbc_pkg::DG_SUPPLY_OV, lin_sbc_pkg::DG_WAKE, lin_sbc_pkg::DG_WDG_TMO};

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // Shared transmit pin has a pull-up; device drive wins while enabled
  assign sda_w = !dut_oe_n ? dut_sda : (!host_oe_n ? host_sda : 1'b1);

  lin_sbc_regs #(.TX_TIMEOUT_CYC(TXTO)) u_lin_sbc_regs (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .vcc_rstn_i(vcc_rstn_i),
    .sp_frame_i(frame), .scl_i(scl), .sda_i(sda_w), .sda_o(dut_sda),
    .sda_oe_n_o(dut_oe_n), .wdg_window_open_i(win_open),
    .supply_uv_i(ev[0]), .regulator_uv_i(ev[1]), .overheat_i(ev[2]),
    .overheat_warn_i(ev[3]), .supply_ov_i(ev[4]), .remote_wake_i(ev[5]),
    .wdg_timeout_i(ev[6]), .lin_tx_enable_o(lin_en),
    .device_control_o(dev_ctl), .temp_shutdown_o(tsd),
    .low_side_data_o(lsd), .wdg_restart_o(restart),
    .reset_req_o(rst_req), .diag_low_o(dlo), .diag_mid_o(dmi));

  lin_sbc_host_model u_lin_sbc_host_model (
    .mclk_i(mclk_i), .sda_i(sda_w), .frame_o(frame), .scl_o(scl),
    .sda_o(host_sda), .sda_oe_n_o(host_oe_n));

  // One-cycle pulses are counted as they happen
  always @(posedge mclk_i) begin
    if (restart === 1'b1) n_restart++;
    if (rst_req === 1'b1) n_rstreq++;
  end

  task automatic wrap_up();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr_burst(input logic [4:0] a, input logic [1:0] len);
    u_lin_sbc_host_model.open_frame(1'b0, len, a);
    for (int i = 0; i < (1 << len); i++) begin
      u_lin_sbc_host_model.put_byte(wdat[i]);
    end
    u_lin_sbc_host_model.close_frame();
  endtask

  task automatic rd_burst(input logic [4:0] a, input logic [1:0] len);
    u_lin_sbc_host_model.open_frame(1'b1, len, a);
    for (int i = 0; i < (1 << len); i++) begin
      u_lin_sbc_host_model.get_byte(got);
      check(got, expd[i]);
    end
    u_lin_sbc_host_model.close_frame();
  endtask

  task automatic wr1(input logic [4:0] a, input logic [7:0] d);
    wdat[0] = d;
    wr_burst(a, 2'b00);
  endtask

  task automatic rd1(input logic [4:0] a, input logic [7:0] e);
    expd[0] = e;
    rd_burst(a, 2'b00);
  endtask

  // Hang guard: a run that never ends counts as a mismatch
  initial begin
    repeat (100000) @(posedge mclk_i);
    miscompares++;
    wrap_up();
  end

  initial begin
    rstn_i = 1'b0;
    vcc_rstn_i = 1'b0;
    win_open = 1'b1;
    ev = '0;
    repeat (20) @(negedge mclk_i);
    rstn_i = 1'b1;
    vcc_rstn_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    check({6'h00, lin_en, dev_ctl}, 8'h03);
    check(dlo, 8'h03);
    check(dmi, 8'h00);
    // Reset values in one eight-byte burst; trigger reads zero
    expd = '{8'h0F, 8'h01, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
    rd_burst(lin_sbc_pkg::OFF_DEV_CFG, 2'b11);
    rd1(lin_sbc_pkg::OFF_DIAG_LO, 8'h00);
    // Reserved high nibble ignored, transceiver disabled
    wr1(lin_sbc_pkg::OFF_DEV_CFG, 8'hF7);
    rd1(lin_sbc_pkg::OFF_DEV_CFG, 8'h07);
    check({7'h00, lin_en}, 8'h00);
    // Two-byte write: control cleared, shutdown entered
    wdat[0] = 8'hFE;
    wdat[1] = 8'h01;
    wr_burst(lin_sbc_pkg::OFF_DEV_CTRL, 2'b01);
    check({6'h00, dev_ctl, tsd}, 8'h01);
    expd[0] = 8'h00;
    expd[1] = 8'h01;
    rd_burst(lin_sbc_pkg::OFF_DEV_CTRL, 2'b01);
    check(dmi, 8'h02);
    rd1(lin_sbc_pkg::OFF_DIAG_MID, 8'h02);
    check(dmi, 8'h00);
    rd1(lin_sbc_pkg::OFF_DIAG_MID, 8'h00);
    // Four bytes from 0x07: only the first lands, flags stay untouched
    wdat = '{8'hA5, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    wr_burst(lin_sbc_pkg::OFF_LSD_DATA, 2'b10);
    check(lsd, 8'hA5);
    expd = '{8'hA5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rd_burst(lin_sbc_pkg::OFF_LSD_DATA, 2'b10);
    // Address wraps from 0x1F to 0x00; last byte reaches 0x03
    wdat = '{8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h08};
    wr_burst(5'h1C, 2'b11);
    rd1(lin_sbc_pkg::OFF_DEV_CFG, 8'h08);
    check({7'h00, lin_en}, 8'h01);
    expd[0] = 8'h00;
    expd[1] = 8'h00;
    rd_burst(5'h1F, 2'b01);
    // Each event sets its own flag; the read clears it again
    for (int i = 0; i < 7; i++) begin
      ev[i] = 1'b1;
      @(negedge mclk_i);
      ev = '0;
      check(dlo, 8'h01 << pos[i]);
      rd1(lin_sbc_pkg::OFF_DIAG_LO, 8'h01 << pos[i]);
      check(dlo, 8'h00);
    end
    rd1(lin_sbc_pkg::OFF_DIAG_LO, 8'h00);
    // Transmit held low outside frames past the timeout
    u_lin_sbc_host_model.tx_level(1'b0);
    repeat (TXTO + 10) @(negedge mclk_i);
    u_lin_sbc_host_model.tx_level(1'b1);
    check(dmi, 8'h01);
    rd1(lin_sbc_pkg::OFF_DIAG_MID, 8'h01);
    check(dmi, 8'h00);
    // Watchdog: bit 0 low is no trigger; open window gives no reset
    win_open = 1'b0;
    wr1(lin_sbc_pkg::OFF_WDG_TRIG, 8'h00);
    check(8'(n_restart), 8'h00);
    win_open = 1'b1;
    wr1(lin_sbc_pkg::OFF_WDG_TRIG, 8'h01);
    check(8'(n_restart), 8'h01);
    check(8'(n_rstreq), 8'h00);
    // Let the trigger bit self-clear before the late trigger
    repeat (4000) @(negedge mclk_i);
    win_open = 1'b0;
    wr1(lin_sbc_pkg::OFF_WDG_TRIG, 8'h01);
    check(8'(n_restart), 8'h02);
    check(8'(n_rstreq), 8'h01);
    // Regulator reset alone: control register keeps its written zero
    vcc_rstn_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    vcc_rstn_i = 1'b1;
    @(negedge mclk_i);
    expd = '{8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rd_burst(lin_sbc_pkg::OFF_DEV_CFG, 2'b11);
    wrap_up();
  end
endmodule
